// file: hw/micro_ops_pkg.sv
package micro_ops_pkg;
  localparam int WORD_W   = 24;
  localparam int LEN_W    = 16;
  localparam int CPL_W    = 5;
  localparam int CNT_W    = 3;
  localparam int SP_DEPTH = 16;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  // micro-instruction opcodes
  localparam logic [7:0]  OP_COUNT   = 8'h06;
  localparam logic [7:0]  OP_SWAP    = 8'h07;
  localparam logic [11:0] OP_CARRY   = 12'h006;
  localparam logic [11:0] OP_ADDFA   = 12'h008;
  localparam logic [11:0] OP_SETCMP  = 12'h00a;
  localparam logic [11:0] OP_TAPE    = 12'h00b;
  localparam logic [11:0] OP_MONITOR = 12'h00c;
  localparam logic [15:0] OP_HALT    = 16'h0001;
  localparam logic [15:0] OP_NORM    = 16'h0003;
  localparam logic [15:0] OP_ZERO    = 16'h0000;
  // count variants
  localparam logic [2:0] CV_FA_UP    = 3'h1;
  localparam logic [2:0] CV_FL_UP    = 3'h2;
  localparam logic [2:0] CV_FAUP_FLD = 3'h3;
  localparam logic [2:0] CV_FAD_FLUP = 3'h4;
  localparam logic [2:0] CV_FA_DN    = 3'h5;
  localparam logic [2:0] CV_FL_DN    = 3'h6;
  localparam logic [2:0] CV_BOTH_DN  = 3'h7;
  // tape and carry variants
  localparam logic [2:0] TV_START    = 3'h0;
  localparam logic [2:0] TV_STOP     = 3'h1;
  localparam logic [2:0] TV_STOP_NE  = 3'h2;
  localparam logic [3:0] CY_CLR      = 4'h1;
  localparam logic [3:0] CY_SET      = 4'h2;
  localparam logic [3:0] CY_LOGIC    = 4'h4;
  localparam logic [3:0] CY_DIFF     = 4'h8;
  localparam logic [2:0] SV_SECONDARY = 3'h2;
  localparam logic [3:0] UNIT_DECIMAL = 4'h4;
  localparam logic [CPL_W-1:0] CPL_MAX = 5'h18;
  // execution clocks
  localparam int CLK_COUNT     = 4;
  localparam int CLK_SWAP      = 4;
  localparam int CLK_ADD       = 4;
  localparam int CLK_SHORT     = 2;
  localparam int CLK_NORM_STEP = 6;
  localparam int CLK_NORM_ZERO = 2;
  localparam int CLK_NORM_BIT  = 4;
  // register map
  localparam logic [ADDR_W-1:0] REG_FA     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FB     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CPL    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_X      = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_Y      = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] REG_HOLD   = 8'h18;
  localparam logic [1:0]        SPL_PAGE   = 2'h1;
  localparam logic [1:0]        SPR_PAGE   = 2'h2;
  // status bits
  localparam int SB_CARRY = 0;
  localparam int SB_TAPE  = 1;
  localparam int SB_INT   = 2;
  localparam int SB_HALT  = 3;
  localparam int SB_BUSY  = 4;
  localparam int SB_STOPP = 5;
  localparam int SB_CPU   = 8;

  typedef struct packed {
    logic [3:0]       unit;
    logic [3:0]       ftype;
    logic [LEN_W-1:0] len;
  } fd_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_NORM = 4'b0100,
    ST_HALT = 4'b1000
  } state_t;
endpackage

// file: hw/field_register_micro_ops.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - count adds or subtracts the 5-bit literal, or compare length when zero
// - field address count wraps both ways with no overflow indication
// - field length up wraps; down below zero clamps to zero
// - 3-bit count variant selects registers and direction; four clocks
// - swap parks address and descriptor, loads from source, stores to destination
// - add-to-address sums a scratchpad word into field address; four clocks
// - monitor operator is a plain no-op
// - cassette variant 0 starts, 1 stops and halts, 2 stops if operands differ
// - tape stops at the next gap; cassette takes two clocks
// - compare unit code is 1 when unit is 4; variant 2 tests secondary unit
// - compare length loads the minimum of the variant-selected values
// - test flag with nonzero compare length skips next instruction; two clocks
// - carry variant 1 clears, 2 sets, 4 logic result, 8 difference result
// - normalize shifts operand left, counting length down, until stop condition
// - compare length 1 selects rightmost bit, 24 the leftmost
// - normalize takes six clocks per shift plus two or four at the end
// - all-zero instruction only advances, in two clocks
// - interrupt conditions cause no hardware action
// - aggregate status bit is the OR of all interrupt conditions
module field_register_micro_ops (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire micro_ops_pkg::bus_req_t       regReq,
  output logic [micro_ops_pkg::DATA_W-1:0]   regRdata,
  input  wire logic                          instrValid,
  input  wire logic [15:0]                   instrWord,
  output logic                               instrReady,
  output logic                               instrDone,
  output logic                               skipNext,
  output logic                               halted,
  input  wire logic                          restart,
  input  wire logic [3:0]                    secondary_unit,
  input  wire logic [micro_ops_pkg::LEN_W-1:0] secondary_length,
  input  wire logic                          carry_logic_result,
  input  wire logic                          carry_diff_result,
  input  wire logic                          tapeGap,
  output logic                               tapeRun,
  input  wire logic [3:0]                    intFlags,
  output logic                               intAny
);
  import micro_ops_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  state_t                  state_reg;
  logic [CNT_W-1:0]        cnt_reg;
  logic                    skip_reg;
  logic                    haltPend_reg;
  logic [WORD_W-1:0]       field_address_reg;
  fd_t                     field_descriptor_reg;
  logic [CPL_W-1:0]        compare_length;
  logic [1:0]              compareUnit_reg;
  logic [WORD_W-1:0]       xReg;
  logic [WORD_W-1:0]       yReg;
  logic [2*WORD_W-1:0]     memory_address_holder;
  logic [WORD_W-1:0]       spLeft [SP_DEPTH];
  logic [WORD_W-1:0]       spRight [SP_DEPTH];
  logic                    carry_flop;
  logic                    stopPend_reg;
  logic [DATA_W-1:0]       readMux;
  logic                    accept;
  logic                    isCount, isSwap, isCarry, isAdd, isSetCmp, isTape, isHalt, isNorm;
  logic [2:0]              variant3;
  logic [CPL_W-1:0]        countAmt;
  logic [LEN_W-1:0]        cpl_next;
  logic                    selBit;
  logic                    normEval, normShift;
  logic [CNT_W-1:0]        waitLoad;
  logic                    tapeStopReq;
  logic [LEN_W-1:0]        flen;
  function automatic logic [LEN_W-1:0] minOf(input logic [LEN_W-1:0] a,
                                             input logic [LEN_W-1:0] b);
    minOf = (a < b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  assign flen       = field_descriptor_reg.len;
  assign instrReady = (state_reg == ST_IDLE);
  assign accept     = instrValid && instrReady;
  assign isCount    = (instrWord[15:8] == OP_COUNT);
  assign isSwap     = (instrWord[15:8] == OP_SWAP);
  assign isCarry    = (instrWord[15:4] == OP_CARRY);
  assign isAdd      = (instrWord[15:4] == OP_ADDFA);
  assign isSetCmp   = (instrWord[15:4] == OP_SETCMP);
  assign isTape     = (instrWord[15:4] == OP_TAPE);
  assign isHalt     = (instrWord == OP_HALT);
  assign isNorm     = (instrWord == OP_NORM);
  assign variant3   = isCount ? instrWord[7:5] : instrWord[2:0];
  assign countAmt   = (instrWord[4:0] == '0) ? compare_length : instrWord[4:0];
  assign tapeStopReq = accept && isTape &&
                       (variant3 == TV_STOP || (variant3 == TV_STOP_NE && xReg != yReg));
  assign intAny     = |intFlags;
  assign halted     = (state_reg == ST_HALT);
  // selected bit of the primary operand
  assign selBit = (compare_length != '0 && compare_length <= CPL_MAX) ?
                  xReg[compare_length - 5'h1] : 1'b0;
  assign normEval  = (state_reg == ST_NORM) && (cnt_reg == '0);
  assign normShift = normEval && (flen != '0) && !selBit;
  always_comb begin
    cpl_next = LEN_W'(compare_length);
    case (variant3)
      3'h0: cpl_next = LEN_W'(isSetCmp ? field_descriptor_reg.unit : 4'h0);
      3'h1: cpl_next = minOf(LEN_W'(CPL_MAX), flen);
      3'h2: cpl_next = minOf(LEN_W'(CPL_MAX), secondary_length);
      3'h3: cpl_next = minOf(minOf(LEN_W'(CPL_MAX), flen), secondary_length);
      3'h5: cpl_next = minOf(minOf(LEN_W'(CPL_MAX), LEN_W'(compare_length)), flen);
      default: cpl_next = LEN_W'(compare_length);
    endcase
  end
  // monitor and unknown codes fall to the short no-op timing
  assign waitLoad = isCount ? CNT_W'(CLK_COUNT - 2) :
                    isSwap  ? CNT_W'(CLK_SWAP - 2) :
                    isAdd   ? CNT_W'(CLK_ADD - 2) :
                              CNT_W'(CLK_SHORT - 2);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= '0;
      skip_reg     <= 1'b0;
      haltPend_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            skip_reg     <= isSetCmp && instrWord[3] && (CPL_W'(cpl_next) != '0);
            haltPend_reg <= isHalt || (isTape && variant3 == TV_STOP);
            cnt_reg      <= isNorm ? '0 : waitLoad;
            state_reg    <= isNorm ? ST_NORM : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cnt_reg == '0) begin
            state_reg    <= haltPend_reg ? ST_HALT : ST_IDLE;
            haltPend_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        ST_NORM: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 3'h1;
          end else if (flen == '0) begin
            state_reg <= ST_IDLE;
          end else if (selBit) begin
            cnt_reg   <= CNT_W'(CLK_NORM_BIT - 3);
            state_reg <= ST_WAIT;
          end else begin
            cnt_reg <= CNT_W'(CLK_NORM_STEP - 1);
          end
        end
        ST_HALT: begin
          if (restart) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // finishing on zero length ends from the evaluation cycle itself
  assign instrDone = ((state_reg == ST_WAIT) && (cnt_reg == '0)) ||
                     (normEval && (flen == '0));
  assign skipNext  = instrDone && skip_reg;

  ////////////////////////////////////////////////////////////////////////////
  // field registers, operand, scratchpad
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      field_address_reg     <= '0;
      field_descriptor_reg  <= '0;
      xReg                  <= '0;
      yReg                  <= '0;
      memory_address_holder <= '0;
      for (int i = 0; i < SP_DEPTH; i++) begin
        spLeft[i]  <= '0;
        spRight[i] <= '0;
      end
    end else if (accept && isCount) begin
      case (variant3)
        CV_FA_UP, CV_FAUP_FLD: field_address_reg <= field_address_reg + WORD_W'(countAmt);
        CV_FAD_FLUP, CV_FA_DN, CV_BOTH_DN:
          field_address_reg <= field_address_reg - WORD_W'(countAmt);
        default: field_address_reg <= field_address_reg;
      endcase
      case (variant3)
        CV_FL_UP, CV_FAD_FLUP: field_descriptor_reg.len <= flen + LEN_W'(countAmt);
        CV_FAUP_FLD, CV_FL_DN, CV_BOTH_DN:
          field_descriptor_reg.len <= (flen < LEN_W'(countAmt)) ? '0 : flen - LEN_W'(countAmt);
        default: field_descriptor_reg.len <= flen;
      endcase
    end else if (accept && isSwap) begin
      memory_address_holder          <= {field_address_reg, field_descriptor_reg};
      field_address_reg              <= spLeft[instrWord[7:4]];
      field_descriptor_reg           <= spRight[instrWord[7:4]];
      spLeft[instrWord[3:0]]         <= field_address_reg;
      spRight[instrWord[3:0]]        <= field_descriptor_reg;
    end else if (accept && isAdd) begin
      field_address_reg <= field_address_reg + spLeft[instrWord[3:0]];
    end else if (normShift) begin
      xReg                     <= {xReg[WORD_W-2:0], 1'b0};
      field_descriptor_reg.len <= flen - 16'h0001;
    end else if (regReq.wr) begin
      case (regReq.addr)
        REG_FA: field_address_reg    <= regReq.wdata[WORD_W-1:0];
        REG_FB: field_descriptor_reg <= regReq.wdata[WORD_W-1:0];
        REG_X:  xReg                 <= regReq.wdata[WORD_W-1:0];
        REG_Y:  yReg                 <= regReq.wdata[WORD_W-1:0];
        default: begin
          if (regReq.addr[7:6] == SPL_PAGE) begin
            spLeft[regReq.addr[5:2]] <= regReq.wdata[WORD_W-1:0];
          end
          if (regReq.addr[7:6] == SPR_PAGE) begin
            spRight[regReq.addr[5:2]] <= regReq.wdata[WORD_W-1:0];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare length, compare unit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      compare_length  <= '0;
      compareUnit_reg <= '0;
    end else if (accept && isSetCmp) begin
      compare_length  <= CPL_W'(cpl_next);
      compareUnit_reg <= {1'b0, (variant3 == SV_SECONDARY) ?
                         (secondary_unit == UNIT_DECIMAL) :
                         (field_descriptor_reg.unit == UNIT_DECIMAL)};
    end else if (regReq.wr && regReq.addr == REG_CPL) begin
      compare_length <= regReq.wdata[CPL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carry flip-flop
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      carry_flop <= 1'b0;
    end else if (accept && isCarry) begin
      case (instrWord[3:0])
        CY_CLR:   carry_flop <= 1'b0;
        CY_SET:   carry_flop <= 1'b1;
        CY_LOGIC: carry_flop <= carry_logic_result;
        CY_DIFF:  carry_flop <= carry_diff_result;
        default:  carry_flop <= carry_flop;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tape: stop requests wait for the next gap; a new request beats the gap
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tapeRun      <= 1'b0;
      stopPend_reg <= 1'b0;
    end else if (accept && isTape && variant3 == TV_START) begin
      tapeRun      <= 1'b1;
      stopPend_reg <= 1'b0;
    end else if (tapeStopReq) begin
      stopPend_reg <= tapeRun;
    end else if (stopPend_reg && tapeGap) begin
      tapeRun      <= 1'b0;
      stopPend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads
  always_comb begin
    readMux = '0;
    case (regReq.addr)
      REG_FA:     readMux = DATA_W'(field_address_reg);
      REG_FB:     readMux = DATA_W'(field_descriptor_reg);
      REG_CPL:    readMux = DATA_W'(compare_length);
      REG_X:      readMux = DATA_W'(xReg);
      REG_Y:      readMux = DATA_W'(yReg);
      REG_HOLD:   readMux = DATA_W'(memory_address_holder[2*WORD_W-1:WORD_W]);
      REG_STATUS: begin
        readMux[SB_CARRY]         = carry_flop;
        readMux[SB_TAPE]          = tapeRun;
        readMux[SB_INT]           = intAny;
        readMux[SB_HALT]          = halted;
        readMux[SB_BUSY]          = !instrReady;
        readMux[SB_STOPP]         = stopPend_reg;
        readMux[SB_CPU+1:SB_CPU]  = compareUnit_reg;
      end
      default: begin
        if (regReq.addr[7:6] == SPL_PAGE) begin
          readMux = DATA_W'(spLeft[regReq.addr[5:2]]);
        end else if (regReq.addr[7:6] == SPR_PAGE) begin
          readMux = DATA_W'(spRight[regReq.addr[5:2]]);
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else begin
      regRdata <= regReq.rd ? readMux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_count_time;
    accept && isCount |-> !instrDone [*3] ##1 instrDone;
  endproperty
  a_count_time: assert property (p_count_time) else $error("count not four clocks");
  property p_fa_up;
    accept && isCount && variant3 == CV_FA_UP |=>
      field_address_reg == $past(field_address_reg) + WORD_W'($past(countAmt));
  endproperty
  a_fa_up: assert property (p_fa_up) else $error("address count wrong");
  property p_zero_literal;
    accept && isCount && variant3 == CV_FA_UP && instrWord[4:0] == '0 |=>
      field_address_reg == $past(field_address_reg) + WORD_W'($past(compare_length));
  endproperty
  a_zero_literal: assert property (p_zero_literal) else $error("zero literal ignored");
  property p_fl_clamp;
    accept && isCount && variant3 == CV_FL_DN && flen < LEN_W'(countAmt) |=> flen == '0;
  endproperty
  a_fl_clamp: assert property (p_fl_clamp) else $error("length underflow wrapped");
  property p_add_fa;
    accept && isAdd |=> field_address_reg ==
      $past(field_address_reg) + spLeft[$past(instrWord[3:0])] ##2 instrDone;
  endproperty
  a_add_fa: assert property (p_add_fa) else $error("add to address wrong");
  property p_short_ops;
    accept && (isTape || isCarry || isSetCmp || instrWord == OP_ZERO) |=> instrDone;
  endproperty
  a_short_ops: assert property (p_short_ops) else $error("short op not two clocks");
  property p_skip;
    skipNext |-> compare_length != '0;
  endproperty
  a_skip: assert property (p_skip) else $error("skip with zero length");
  property p_carry_set;
    accept && isCarry && instrWord[3:0] == CY_SET |=> carry_flop;
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry not set");
  property p_norm_step;
    normShift |=> flen == $past(flen) - 16'h0001 ##0 !normEval [*5] ##1 normEval;
  endproperty
  a_norm_step: assert property (p_norm_step) else $error("normalize step wrong");
  property p_int_or;
    regReq.addr == REG_STATUS |-> readMux[SB_INT] == (intFlags != 4'h0);
  endproperty
  a_int_or: assert property (p_int_or) else $error("aggregate bit wrong");
  property p_halt;
    accept && isHalt |=> instrDone ##1 (halted && !instrReady);
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop");
  c_norm_bit:  cover property (normEval && selBit && flen != '0);
  c_skip:      cover property (skipNext);
  c_tape_stop: cover property (stopPend_reg && tapeGap);
  c_restart:   cover property (halted && restart);
endmodule
`default_nettype wire

// file: bench/instr_feeder.sv
`timescale 1ns/1ns
`default_nettype none
module instr_feeder (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [15:0] word,
  input  wire logic        instrReady,
  output logic             instrValid,
  output logic [15:0]      instrWord
);
  // offer held until taken; word toggles while nothing is offered
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      instrValid <= 1'b0;
      instrWord  <= 16'h5a5a;
    end else if (instrValid && instrReady) begin
      instrValid <= 1'b0;
      instrWord  <= ~instrWord;
    end else if (go && !instrValid) begin
      instrValid <= 1'b1;
      instrWord  <= word;
    end else if (!instrValid) begin
      instrWord <= ~instrWord;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_field_register_micro_ops.sv
`timescale 1ns/1ns
`default_nettype none
module tb_field_register_micro_ops;
  import micro_ops_pkg::*;
  logic clk_sys, nrst, go, restart, cLog, cDif, tapeGap, skp;
  logic instrValid, instrReady, instrDone, skipNext, halted, tapeRun, intAny;
  logic [15:0] word, instrWord, secLen;
  logic [3:0]  intFlags, secUnit;
  logic [31:0] regRdata;
  bus_req_t    regReq;
  int errors, compares, cyc;
  int faD[8] = '{0, 1, 0, 1, -1, -1, 0, -1};
  int flD[8] = '{0, 0, 1, -1, 1, 0, -1, -1};
  logic [3:0] cyV[4] = '{4'h2, 4'h1, 4'h4, 4'h8};
  logic [31:0] cyE[4] = '{32'h1, 32'h0, 32'h1, 32'h0};

  field_register_micro_ops dut (.clk_sys(clk_sys), .nrst(nrst), .regReq(regReq),
    .regRdata(regRdata), .instrValid(instrValid), .instrWord(instrWord),
    .instrReady(instrReady), .instrDone(instrDone), .skipNext(skipNext), .halted(halted),
    .restart(restart), .secondary_unit(secUnit), .secondary_length(secLen),
    .carry_logic_result(cLog), .carry_diff_result(cDif), .tapeGap(tapeGap),
    .tapeRun(tapeRun), .intFlags(intFlags), .intAny(intAny));
  instr_feeder feeder (.clk_sys(clk_sys), .nrst(nrst), .go(go), .word(word),
    .instrReady(instrReady), .instrValid(instrValid), .instrWord(instrWord));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys) regReq <= '0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys) regReq <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk_sys) regReq <= '0;
    @(negedge clk_sys) chk(regRdata, e);
  endtask
  // offers one word, checks its length in clocks from the take cycle
  task automatic ex(input logic [15:0] w, input int n);
    int c;
    @(posedge clk_sys);
    go <= 1'b1;
    word <= w;
    @(posedge clk_sys) go <= 1'b0;
    @(negedge clk_sys);
    c = 0;
    while (!(instrValid && instrReady) && c < 50) begin
      c++;
      @(negedge clk_sys);
    end
    c = 1;
    @(negedge clk_sys);
    while (instrDone !== 1'b1 && c < 500) begin
      c++;
      @(negedge clk_sys);
    end
    skp = skipNext;
    chk(32'(c + 1), 32'(n));
  endtask
  task automatic kick();
    @(posedge clk_sys) restart <= 1'b1;
    @(posedge clk_sys) restart <= 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end
  initial begin
    nrst = 1'b0; go = 1'b0; word = '0; restart = 1'b0; cLog = 1'b1; cDif = 1'b0;
    tapeGap = 1'b0; intFlags = '0; secUnit = '0; secLen = 16'h5; regReq = '0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rc(REG_FA, 0);
    rc(REG_STATUS, 0);
    rc(8'hf0, 0);
    $display("reset test done");
    for (int v = 0; v < 8; v++) begin
      wr(REG_FA, 32'h10);
      wr(REG_FB, 32'h10);
      ex({OP_COUNT, 3'(v), 5'h01}, CLK_COUNT);
      rc(REG_FA, 32'(16 + faD[v]));
      rc(REG_FB, 32'(16 + flD[v]));
    end
    wr(REG_CPL, 32'h7);
    wr(REG_FA, 32'h5);
    ex(16'h0620, 4);
    rc(REG_FA, 32'hc);
    wr(REG_FA, 32'h1);
    ex(16'h06a2, 4);
    rc(REG_FA, 32'hffffff);
    wr(REG_FB, 32'h2);
    ex(16'h06c5, 4);
    rc(REG_FB, 32'h0);
    wr(REG_FB, 32'hffff);
    ex(16'h0641, 4);
    rc(REG_FB, 32'h0);
    $display("count tests done");
    for (int i = 0; i < 4; i++) begin
      ex({OP_CARRY, cyV[i]}, 2);
      rc(REG_STATUS, cyE[i]);
    end
    wr(REG_FB, 32'h40001e);
    ex(16'h00a9, 2);
    chk(skp, 1);
    rc(REG_CPL, 32'h18);
    rc(REG_STATUS, 32'h100);
    ex(16'h00a2, 2);
    chk(skp, 0);
    rc(REG_CPL, 32'h5);
    rc(REG_STATUS, 32'h0);
    ex(16'h00a0, 2);
    rc(REG_CPL, 32'h4);
    ex(16'h00ab, 2);
    chk(skp, 1);
    rc(REG_CPL, 32'h5);
    $display("carry and compare tests done");
    wr(REG_CPL, 32'h18);
    wr(REG_X, 32'h1);
    wr(REG_FB, 32'h3);
    ex(OP_NORM, 20);
    rc(REG_X, 32'h8);
    wr(REG_X, 32'h400000);
    wr(REG_FB, 32'h5);
    ex(OP_NORM, 10);
    rc(REG_X, 32'h800000);
    rc(REG_FB, 32'h4);
    wr(REG_CPL, 32'h1);
    wr(REG_X, 32'h1);
    wr(REG_FB, 32'h3);
    ex(OP_NORM, 4);
    rc(REG_X, 32'h1);
    $display("normalize tests done");
    wr(8'h4c, 32'h100);
    wr(REG_FA, 32'h20);
    ex(16'h0083, 4);
    rc(REG_FA, 32'h120);
    wr(REG_FA, 32'haa);
    wr(REG_FB, 32'hbb);
    wr(8'h44, 32'h11);
    wr(8'h84, 32'h22);
    ex(16'h0712, CLK_SWAP);
    rc(REG_FA, 32'h11);
    rc(REG_FB, 32'h22);
    rc(8'h48, 32'haa);
    rc(8'h88, 32'hbb);
    rc(REG_HOLD, 32'haa);
    ex(16'h00c0, 2);
    ex(OP_ZERO, 2);
    rc(REG_FA, 32'h11);
    $display("datapath tests done");
    @(posedge clk_sys) intFlags <= 4'h4;
    @(negedge clk_sys) chk(intAny, 1);
    chk(instrReady, 1);
    ex(OP_HALT, 2);
    @(negedge clk_sys) chk(halted, 1);
    kick();
    chk(halted, 0);
    ex(16'h00b0, 2);
    ex(16'h00b1, 2);
    repeat (3) @(negedge clk_sys);
    chk(tapeRun, 1);
    chk(halted, 1);
    rc(REG_STATUS, 32'h13e);
    @(posedge clk_sys) tapeGap <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(tapeRun, 0);
    kick();
    $display("halt and tape tests done");
    results();
  end
endmodule
`default_nettype wire
